/* File: rtl/adcsr_core.sv */
// holds the serial readout, conversion timing and apb registers of the converter
// assumes the host pins are asynchronous; the sample word is written by software
// Summary of operation
// - select input high at convert rise starts conversion, select mode, output floats
// - select input and convert_start both low forces the data output driven low
// - conversion end enters acquisition and powers down until the next request
// - select falling after conversion shows msb; each clock fall shows next bit
// - each bit holds across the serial clock rise and moves on the clock fall
// - without busy, output floats after 16th clock fall or select rise
// - with busy in select mode output goes driven low at conversion end
// - with busy, bits follow on clock falls; float at 17th fall or select rise
// - clock low and select low at convert rise start chain mode, busy off
// - chain without busy shows msb at conversion end, rest on clock falls
// - in chain mode select input feeds the shift register on each clock fall
// - clock high and select low at convert rise start chain mode, busy on
// - chain with busy drives the output high when conversion is done
// - select level at each convert rise outside conversion picks select or chain mode
//
// Added by the designer: the register addresses and register access over APB.
module adcsr_core (
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        convert_start_i,
	input  wire logic        serial_select_in_i,
	input  wire logic        serial_clock_i,
	output logic             serial_data_out_o,
	output logic             serial_data_out_oe_o
);

	// ***********************************************
	// pin synchronisers
	// ***********************************************
	adcsr_pins_if pins ();

	adcsr_pin_sync u_sync (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.pins_i    ({serial_clock_i, serial_select_in_i, convert_start_i}),
		.pins      (pins.src)
	);

	logic start_lvl;
	logic start_rise;
	logic ssi_lvl;
	logic ssi_rise;
	logic ssi_fall;
	logic sclk_lvl;
	logic sclk_fall;

	assign start_lvl  = pins.lvl[adcsr_pkg::PIN_CONV_START];
	assign start_rise = pins.rise[adcsr_pkg::PIN_CONV_START];
	assign ssi_lvl   = pins.lvl[adcsr_pkg::PIN_SSI];
	assign ssi_rise  = pins.rise[adcsr_pkg::PIN_SSI];
	assign ssi_fall  = pins.fall[adcsr_pkg::PIN_SSI];
	assign sclk_lvl  = pins.lvl[adcsr_pkg::PIN_SCLK];
	assign sclk_fall = pins.fall[adcsr_pkg::PIN_SCLK];

	// ***********************************************
	// state
	// ***********************************************
	adcsr_pkg::adcsr_state_t state;
	logic [15:0]             sample;
	logic [15:0]             conv_time;
	logic [15:0]             conv_cnt;
	logic [15:0]             data_word;
	logic [16:0]             shreg;
	logic [4:0]              bit_cnt;
	logic                    select_mode;
	logic                    busy_en;
	logic                    released;
	logic                    pwr_down;
	logic                    conv_done;
	logic                    out_bit;
	logic [4:0]              frame_len;
	logic [15:0]             eff_time;
	logic                    next_oe;
	logic                    next_dout;
	logic                    wr_en;
	logic                    acc;

	assign conv_done = (state == adcsr_pkg::ST_CONV) && (conv_cnt == 16'h0000);
	assign out_bit   = busy_en ? shreg[16] : shreg[15];
	assign frame_len = busy_en ? adcsr_pkg::LEN_BUSY : adcsr_pkg::LEN_PLAIN;
	// a too short setting would let the host read before the word exists
	assign eff_time  = (conv_time < adcsr_pkg::CONV_MIN_CYC) ? adcsr_pkg::CONV_MIN_CYC : conv_time;

	// ***********************************************
	// apb slave
	// ***********************************************
	// one wait state keeps every bus output on a flip-flop
	assign acc   = psel_i && penable_i;
	assign wr_en = acc && pready_o && pwrite_i;

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= acc && !pready_o;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
			if (acc && !pready_o) begin
				unique case (paddr_i)
					adcsr_pkg::REG_SAMPLE: begin
						prdata_o <= {16'h0000, sample};
					end
					adcsr_pkg::REG_CONV_TIME: begin
						prdata_o <= {16'h0000, conv_time};
					end
					adcsr_pkg::REG_STATUS: begin
						prdata_o[adcsr_pkg::ST_STATE_LSB +: 3] <= state;
						prdata_o[adcsr_pkg::ST_SELECT_BIT]     <= select_mode;
						prdata_o[adcsr_pkg::ST_BUSY_BIT]       <= busy_en;
						prdata_o[adcsr_pkg::ST_PWRDN_BIT]      <= pwr_down;
						prdata_o[adcsr_pkg::ST_OE_BIT]         <= serial_data_out_oe_o;
						prdata_o[adcsr_pkg::ST_CNT_LSB +: 5]   <= bit_cnt;
					end
					default: begin
						pslverr_o <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sample    <= adcsr_pkg::SAMPLE_RST;
			conv_time <= adcsr_pkg::CONV_TIME_RST;
		end else if (wr_en) begin
			if (paddr_i == adcsr_pkg::REG_SAMPLE) begin
				sample <= pwdata_i[15:0];
			end
			if (paddr_i == adcsr_pkg::REG_CONV_TIME) begin
				conv_time <= pwdata_i[15:0];
			end
		end
	end

	// ***********************************************
	// conversion sequencing
	// ***********************************************
	// a convert rise during conversion is ignored: the conversion runs to its end
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state     <= adcsr_pkg::ST_IDLE;
			conv_cnt  <= 16'h0000;
			data_word <= 16'h0000;
			pwr_down  <= 1'b1;
		end else begin
			unique case (state)
				adcsr_pkg::ST_IDLE, adcsr_pkg::ST_READ: begin
					if (start_rise) begin
						state     <= adcsr_pkg::ST_CONV;
						conv_cnt  <= eff_time - 16'h0001;
						data_word <= sample;
						pwr_down  <= 1'b0;
					end
				end
				adcsr_pkg::ST_CONV: begin
					if (conv_done) begin
						state    <= adcsr_pkg::ST_READ;
						pwr_down <= 1'b1;
					end else begin
						conv_cnt <= conv_cnt - 16'h0001;
					end
				end
			endcase
		end
	end

	// ***********************************************
	// mode selection
	// ***********************************************
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			select_mode <= 1'b1;
			busy_en     <= 1'b0;
		end else if (state != adcsr_pkg::ST_CONV && start_rise) begin
			select_mode <= ssi_lvl;
			busy_en     <= !ssi_lvl && sclk_lvl;
		end else if (conv_done && select_mode) begin
			// busy comes when the host holds select low over the end
			busy_en <= !ssi_lvl;
		end
	end

	// ***********************************************
	// output shift register
	// ***********************************************
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			shreg    <= 17'h00000;
			bit_cnt  <= 5'h00;
			released <= 1'b1;
		end else if (state != adcsr_pkg::ST_CONV && start_rise) begin
			released <= 1'b0;
			bit_cnt  <= 5'h00;
		end else if (conv_done) begin
			bit_cnt <= 5'h00;
			if (select_mode) begin
				// the top bit is the busy zero; without busy the output taps one below it
				shreg <= {1'b0, data_word};
			end else if (busy_en) begin
				shreg <= {1'b1, data_word};
			end else begin
				shreg <= {1'b0, data_word};
			end
		end else if (state == adcsr_pkg::ST_READ) begin
			if (select_mode) begin
				if (ssi_rise) begin
					released <= 1'b1;
				end else if (sclk_fall && !ssi_lvl && !released) begin
					shreg   <= {shreg[15:0], 1'b0};
					bit_cnt <= bit_cnt + 5'h01;
					if (bit_cnt + 5'h01 == frame_len) begin
						released <= 1'b1;
					end
				end
			end else if (sclk_fall) begin
				// upstream data enters at the bottom and walks to the output
				shreg <= {shreg[15:0], ssi_lvl};
				if (bit_cnt != 5'h1F) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
			end
		end
	end

	// ***********************************************
	// data output drive
	// ***********************************************
	// the bit only moves on a clock fall, so it holds over the rising edge
	always_comb begin
		next_oe   = 1'b0;
		next_dout = 1'b0;
		if (!ssi_lvl && !start_lvl) begin
			next_oe = 1'b1;
		end else if (!select_mode) begin
			next_oe   = 1'b1;
			next_dout = (state == adcsr_pkg::ST_READ) && out_bit;
		end else if (state == adcsr_pkg::ST_READ && !released && !ssi_lvl) begin
			next_oe   = 1'b1;
			next_dout = out_bit;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			serial_data_out_o    <= 1'b0;
			serial_data_out_oe_o <= 1'b0;
		end else begin
			serial_data_out_o    <= next_dout;
			serial_data_out_oe_o <= next_oe;
		end
	end

	// ***********************************************
	// checks
	// ***********************************************
	logic pin_evt;
	assign pin_evt = pins.rise[adcsr_pkg::PIN_CONV_START] || pins.fall[adcsr_pkg::PIN_CONV_START] || ssi_rise
		|| ssi_fall || sclk_fall || conv_done || start_rise;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sel_float_a: assert property (state != adcsr_pkg::ST_CONV && start_rise && ssi_lvl ##1 start_lvl
		|-> ##1 !serial_data_out_oe_o) else $error("output not floated at select start");
	drive_low_a: assert property (!ssi_lvl && !start_lvl |=> serial_data_out_oe_o && !serial_data_out_o)
		else $error("output not driven low with both inputs low");
	power_down_a: assert property (conv_done |=> pwr_down && state == adcsr_pkg::ST_READ)
		else $error("no power down after conversion");
	sel_msb_a: assert property (state == adcsr_pkg::ST_READ && select_mode && !busy_en && !released
		&& ssi_fall && start_lvl ##1 (!ssi_lvl && start_lvl)
		|-> ##1 serial_data_out_oe_o && serial_data_out_o == data_word[15])
		else $error("msb not shown on select fall");
	bit_hold_a: assert property (!pin_evt ##1 !pin_evt |-> ##1 $stable(serial_data_out_o))
		else $error("output bit moved without a clock fall");
	float_16_a: assert property (state == adcsr_pkg::ST_READ && select_mode && !busy_en && !released
		&& sclk_fall && !ssi_lvl && bit_cnt == 5'h0F |-> ##2 (!serial_data_out_oe_o || !start_lvl))
		else $error("output still driven after sixteenth fall");
	sel_rise_a: assert property (state == adcsr_pkg::ST_READ && select_mode && ssi_rise && !start_rise
		|=> released) else $error("output not released on select rise");
	busy_low_a: assert property (conv_done && select_mode && !ssi_lvl ##1 (!ssi_lvl && start_lvl)
		|-> ##1 serial_data_out_oe_o && !serial_data_out_o) else $error("busy low missing");
	float_17_a: assert property (state == adcsr_pkg::ST_READ && select_mode && busy_en && !released
		&& sclk_fall && !ssi_lvl && bit_cnt == 5'h10 |-> ##2 (!serial_data_out_oe_o || !start_lvl))
		else $error("output still driven after seventeenth fall");
	chain_mode_a: assert property (state != adcsr_pkg::ST_CONV && start_rise && !ssi_lvl
		|=> !select_mode && busy_en == $past(sclk_lvl)) else $error("chain mode or busy wrong");
	chain_msb_a: assert property (conv_done && !select_mode && !busy_en ##1 start_lvl
		|-> ##1 serial_data_out_oe_o && serial_data_out_o == data_word[15])
		else $error("chain msb not shown");
	chain_busy_a: assert property (conv_done && !select_mode && busy_en ##1 start_lvl
		|-> ##1 serial_data_out_oe_o && serial_data_out_o) else $error("chain busy high missing");
	chain_shift_a: assert property (state == adcsr_pkg::ST_READ && !select_mode && sclk_fall && !start_rise
		|=> shreg[0] == $past(ssi_lvl)) else $error("chain input not captured");

	sel_read_c: cover property (select_mode && !busy_en && bit_cnt == 5'h10 && released);
	sel_busy_c: cover property (select_mode && busy_en && bit_cnt == 5'h11);
	chain_read_c: cover property (!select_mode && bit_cnt == 5'h10);
	apb_err_c: cover property (pready_o && pslverr_o);

endmodule

/* File: rtl/adcsr_pkg.sv */
// holds the shared constants and types of the serial readout block
// assumes a 50 MHz system clock and a 32-bit apb register bus
package adcsr_pkg;

	// ***********************************************
	// register map
	// ***********************************************
	localparam logic [7:0]  REG_SAMPLE      = 8'h00;
	localparam logic [7:0]  REG_CONV_TIME   = 8'h04;
	localparam logic [7:0]  REG_STATUS      = 8'h08;
	localparam logic [15:0] SAMPLE_RST      = 16'h0000;

	// ***********************************************
	// status fields
	// ***********************************************
	localparam int ST_STATE_LSB  = 0;
	localparam int ST_SELECT_BIT = 3;
	localparam int ST_BUSY_BIT   = 4;
	localparam int ST_PWRDN_BIT  = 5;
	localparam int ST_OE_BIT     = 6;
	localparam int ST_CNT_LSB    = 8;

	// ***********************************************
	// timing
	// ***********************************************
	localparam int          CLK_PERIOD_NS  = 20;
	localparam int          T_CONV_MIN_NS  = 500;
	localparam int          T_CONV_MAX_NS  = 700;
	localparam logic [15:0] CONV_MIN_CYC   = 16'((T_CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] CONV_TIME_RST  = 16'((T_CONV_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ***********************************************
	// word framing
	// ***********************************************
	localparam logic [4:0]  LEN_PLAIN      = 5'h10;
	localparam logic [4:0]  LEN_BUSY       = 5'h11;

	// ***********************************************
	// pin indices
	// ***********************************************
	localparam int PIN_CONV_START = 0;
	localparam int PIN_SSI        = 1;
	localparam int PIN_SCLK       = 2;
	localparam int PIN_NUM        = 3;
	// idle pin levels: select rests high, so reset must not leave a false edge behind
	localparam logic [PIN_NUM-1:0] PIN_IDLE = 3'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_READ = 3'b100
	} adcsr_state_t;

endpackage

/* File: rtl/adcsr_pins_if.sv */
// carries the synchronised pin levels and their edge pulses
// assumes all members change on the system clock only
interface adcsr_pins_if;
	logic [adcsr_pkg::PIN_NUM-1:0] lvl;
	logic [adcsr_pkg::PIN_NUM-1:0] rise;
	logic [adcsr_pkg::PIN_NUM-1:0] fall;

	modport src (output lvl, output rise, output fall);
	modport snk (input lvl, input rise, input fall);
endinterface

/* File: rtl/adcsr_pin_sync.sv */
// holds the two-flop synchronisers and edge finders for the host pins
// assumes the pins are asynchronous to sys_clk_i
module adcsr_pin_sync (
	input  wire logic                          sys_clk_i,
	input  wire logic                          sys_rst_i,
	input  wire logic [adcsr_pkg::PIN_NUM-1:0] pins_i,
	adcsr_pins_if.src                          pins
);

	logic [adcsr_pkg::PIN_NUM-1:0] meta;
	logic [adcsr_pkg::PIN_NUM-1:0] sync;
	logic [adcsr_pkg::PIN_NUM-1:0] prev;

	// ***********************************************
	// per pin synchroniser
	// ***********************************************
	// the first stage feeds the second stage only
	for (genvar i = 0; i < adcsr_pkg::PIN_NUM; i++) begin : g_pin
		always_ff @(posedge sys_clk_i) begin
			if (sys_rst_i) begin
				meta[i] <= adcsr_pkg::PIN_IDLE[i];
				sync[i] <= adcsr_pkg::PIN_IDLE[i];
				prev[i] <= adcsr_pkg::PIN_IDLE[i];
			end else begin
				meta[i] <= pins_i[i];
				sync[i] <= meta[i];
				prev[i] <= sync[i];
			end
		end
		assign pins.lvl[i]  = sync[i];
		assign pins.rise[i] = sync[i] & ~prev[i];
		assign pins.fall[i] = ~sync[i] & prev[i];
	end

endmodule

/* File: sim/adcsr_host.sv */
// host model of the converter pins: convert start, select, serial clock, sampled data line
// assumes the bench calls its tasks right after a rising edge of sys_clk_i
module adcsr_host (
	input  wire logic       sys_clk_i,
	input  wire logic       serial_data_out_i,
	input  wire logic       serial_data_out_oe_i,
	output logic            convert_start_o,
	output logic            serial_select_o,
	output logic            serial_clock_o,
	output logic            smp_v_o,
	output logic      [2:0] smp_o
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic line;

	// pull-up on the shared line, so a released output reads high
	assign line = serial_data_out_oe_i ? serial_data_out_i : 1'b1;

	initial begin
		convert_start_o = 1'b0;
		serial_select_o = 1'b1;
		serial_clock_o  = 1'b0;
		smp_v_o         = 1'b0;
		smp_o           = 3'h0;
	end

	task automatic drive(input logic c, input logic s, input logic k);
		convert_start_o <= c;
		serial_select_o <= s;
		serial_clock_o  <= k;
		@(posedge sys_clk_i);
	endtask

	task automatic look();
		smp_o   <= {1'b0, serial_data_out_oe_i, line};
		smp_v_o <= 1'b1;
		@(posedge sys_clk_i);
		smp_v_o <= 1'b0;
	endtask

	// one 160 ns period; the bit is taken after the rise and watched up to the fall
	task automatic clk_bit(input logic up);
		logic [1:0] v;
		logic       ch;
		serial_select_o <= up;
		serial_clock_o  <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		v  = {serial_data_out_oe_i, line};
		ch = 1'b0;
		repeat (2) begin
			@(posedge sys_clk_i);
			ch = ch | ({serial_data_out_oe_i, line} !== v);
		end
		smp_o          <= {ch, v};
		smp_v_o        <= 1'b1;
		serial_clock_o <= 1'b0;
		@(posedge sys_clk_i);
		smp_v_o <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
	endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench of the serial readout block: apb master, host pin model, result queues
// assumes adcsr_core and the host model adcsr_host
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic        err;
		logic [31:0] d;
		logic [31:0] m;
	} adcsr_apb_exp_t;
	localparam logic [31:0] CT  = {16'h0000, adcsr_pkg::CONV_MIN_CYC};
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	localparam logic [31:0] PWR = 32'h1 << adcsr_pkg::ST_PWRDN_BIT;
	localparam logic [31:0] ST0 = (32'h1 << adcsr_pkg::ST_STATE_LSB) | (32'h1 << adcsr_pkg::ST_SELECT_BIT) | PWR;
	logic           sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic           start, sel, sclk, dout, dout_oe, smp_v;
	logic     [7:0] paddr;
	logic    [31:0] pwdata, prdata;
	logic     [2:0] smp;
	logic    [31:0] rnd = 32'hAFDED5B6;
	adcsr_apb_exp_t apb_q[$];
	logic     [2:0] bit_q[$];
	int             n_mismatch = 0;
	int             check_count = 0;

	adcsr_core adcsr_core_i (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .convert_start_i(start), .serial_select_in_i(sel), .serial_clock_i(sclk),
		.serial_data_out_o(dout), .serial_data_out_oe_o(dout_oe));
	adcsr_host adcsr_host_i (.sys_clk_i(sys_clk), .serial_data_out_i(dout), .serial_data_out_oe_i(dout_oe),
		.convert_start_o(start), .serial_select_o(sel), .serial_clock_o(sclk), .smp_v_o(smp_v), .smp_o(smp));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic fail(input logic [32:0] g, input logic [32:0] e);
		n_mismatch++;
		$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
	endtask
	task automatic cmp_apb(input adcsr_apb_exp_t e);
		check_count++;
		if (pslverr !== e.err || ((prdata ^ e.d) & e.m) !== 32'h0) fail({pslverr, prdata}, {e.err, e.d});
	endtask
	task automatic cmp_bit(input logic [2:0] e);
		check_count++;
		if (smp !== e) fail({30'h0, smp}, {30'h0, e});
	endtask
	task automatic complete_run();
		if (apb_q.size() != 0 || bit_q.size() != 0) n_mismatch++;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ***********************************************
	// apb master: holds the request until pready is seen
	// ***********************************************
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic e);
		adcsr_apb_exp_t x;
		x.err = e;
		x.d   = d;
		x.m   = wr ? 32'h0 : m;
		apb_q.push_back(x);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// md: 0 select, 1 select cut short, 2 select busy, 3 chain of two, 4 chain busy
	task automatic conv(input int md);
		logic [15:0] w;
		logic [15:0] u;
		logic        ld;
		logic        b;
		int          n;
		rnd = lfsr_next(rnd);
		w   = rnd[15:0];
		u   = rnd[31:16];
		ld  = (md == 2 || md == 4);
		n   = (md == 1) ? 5 : (md == 3) ? 32 : 16 + int'(ld);
		apb(1'b1, adcsr_pkg::REG_SAMPLE, {16'h0000, w}, 32'h0, 1'b0);
		adcsr_host_i.drive(1'b0, md < 3, md == 4);
		repeat (8) @(posedge sys_clk);
		if (md >= 3) begin
			bit_q.push_back(3'b010);
			adcsr_host_i.look();
		end
		adcsr_host_i.drive(1'b1, md < 3, md == 4);
		repeat (12) @(posedge sys_clk);
		if (md < 3) begin
			bit_q.push_back(3'b001);
			adcsr_host_i.look();
		end
		if (md == 2) adcsr_host_i.drive(1'b1, 1'b0, 1'b0);
		repeat (CT + 10) @(posedge sys_clk);
		if (md < 2) adcsr_host_i.drive(1'b1, 1'b0, 1'b0);
		repeat (8) @(posedge sys_clk);
		for (int i = 0; i < n; i++) begin
			if (ld && i == 0) b = (md == 4);
			else if (i - int'(ld) < 16) b = w[15 - i + int'(ld)];
			else b = u[31 - i];
			bit_q.push_back({2'b01, b});
			adcsr_host_i.clk_bit(md >= 3 ? u[15 - i % 16] : 1'b0);
		end
		if (md == 1) begin
			adcsr_host_i.drive(1'b1, 1'b1, 1'b0);
			repeat (4) @(posedge sys_clk);
		end
		if (md < 3) begin
			repeat (4) @(posedge sys_clk);
			bit_q.push_back(3'b001);
			adcsr_host_i.look();
		end
		apb(1'b0, adcsr_pkg::REG_STATUS, PWR, PWR, 1'b0);
		adcsr_host_i.drive(1'b0, 1'b1, 1'b0);
		repeat (8) @(posedge sys_clk);
	endtask

	always @(posedge sys_clk) begin
		if (pready === 1'b1) begin
			if (apb_q.size() > 0) cmp_apb(apb_q.pop_front());
			else fail({pslverr, prdata}, 33'h0);
		end
		if (smp_v === 1'b1) begin
			if (bit_q.size() > 0) cmp_bit(bit_q.pop_front());
			else fail({30'h0, smp}, 33'h0);
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// the whole run needs about 1200 cycles
	initial begin
		repeat (6000) @(posedge sys_clk);
		fail(33'h0, 33'h1);
		complete_run();
	end

	initial begin
		sys_rst = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge sys_clk);
		bit_q.push_back(3'b001);
		adcsr_host_i.look();
		apb(1'b0, adcsr_pkg::REG_SAMPLE, 32'(adcsr_pkg::SAMPLE_RST), ALL, 1'b0);
		apb(1'b0, adcsr_pkg::REG_CONV_TIME, 32'(adcsr_pkg::CONV_TIME_RST), ALL, 1'b0);
		apb(1'b0, adcsr_pkg::REG_STATUS, ST0, ALL, 1'b0);
		apb(1'b1, adcsr_pkg::REG_STATUS, ALL, 32'h0, 1'b0);
		apb(1'b0, adcsr_pkg::REG_STATUS, ST0, ALL, 1'b0);
		apb(1'b1, 8'h0C, ALL, 32'h0, 1'b1);
		apb(1'b0, 8'h0C, 32'h0, ALL, 1'b1);
		apb(1'b1, adcsr_pkg::REG_CONV_TIME, CT, 32'h0, 1'b0);
		apb(1'b0, adcsr_pkg::REG_CONV_TIME, CT, ALL, 1'b0);
		for (int md = 0; md < 5; md++) conv(md);
		complete_run();
	end
endmodule
